// >>> sim/aocc_host.sv
// Programming host model for the configuration word port.
// Assumes the block clock; drives at the falling edge.
`timescale 1ns/100ps
`default_nettype none
module aocc_host (
	input  wire logic        sys_clk_i,
	input  wire logic [15:0] rdata_i,
	output var  logic [3:0]  addr_o,
	output var  logic        wr_o,
	output var  logic [15:0] wdata_o
);
	initial begin
		addr_o = 4'h0;
		wr_o = 1'b0;
		wdata_o = 16'h0000;
	end
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(negedge sys_clk_i);
		addr_o = a;
		wdata_o = (a inside {4'hb, 4'hc}) ? d & 16'h1fff : d;
		wr_o = 1'b1;
		@(negedge sys_clk_i);
		wr_o = 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(negedge sys_clk_i);
		addr_o = a;
		@(negedge sys_clk_i);
		d = rdata_i;
	endtask : rd
endmodule : aocc_host
`default_nettype wire

// >>> sim/aocc_sva.sv
// Assertions on the aocc_top ports.
// Assumes it is bound onto aocc_top, one clock.
`timescale 1ns/100ps
`default_nettype none
module aocc_sva (
	input wire logic        sys_clk_i,
	input wire logic        srst_i,
	input wire logic [3:0]  reg_addr_i,
	input wire logic        reg_wr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic [12:0] dac_code_o,
	input wire logic [1:0]  diag_level_o,
	input wire logic        slope_fall_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	sequence s_wr(a);
		reg_wr_i && reg_addr_i == a ##1 !reg_wr_i && $stable(reg_addr_i);
	endsequence
	a_lo_read: assert property (s_wr(4'hb) |=>
		reg_rdata_o == ($past(reg_wdata_i, 2) & 16'h7fff)) else $error("lo");
	a_hi_read: assert property (s_wr(4'hc) |=>
		reg_rdata_o == $past(reg_wdata_i, 2)) else $error("hi");
	a_gain_read: assert property (s_wr(4'h9) |=>
		reg_rdata_o == $past(reg_wdata_i, 2)) else $error("gain");
	a_opts_read: assert property (s_wr(4'ha) |=>
		reg_rdata_o == $past(reg_wdata_i, 2)) else $error("opts");
	a_opts_out: assert property (reg_wr_i && reg_addr_i == 4'ha
		##1 !reg_wr_i [*2] |=> {diag_level_o, slope_fall_o} ==
		$past(reg_wdata_i[15:13], 3)) else $error("opts out");
	a_dac_ceil: assert property (dac_code_o <= 13'h1300)
		else $error("dac high");
	a_dac_floor: assert property (dac_code_o >= 13'h0100)
		else $error("dac low");
	a_dac_reset: assert property (disable iff (1'b0)
		srst_i |=> dac_code_o == 13'h0100) else $error("dac reset");
endmodule : aocc_sva
bind aocc_top aocc_sva aocc_sva_i (.sys_clk_i, .srst_i, .reg_addr_i,
	.reg_wr_i, .reg_wdata_i, .reg_rdata_o, .dac_code_o, .diag_level_o,
	.slope_fall_o);
`default_nettype wire

// >>> sim/aocc_top_tb_top.sv
// Self-checking bench for aocc_top driven by the host model.
// Assumes 125 MHz clock and synchronous high reset.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
	$display("BAD t=%0t got %h exp %h", $time, g, e); end end
module aocc_top_tb_top;
	logic        sys_clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic [15:0] angle_i = 16'h0000;
	logic [15:0] zero = 16'h0000;
	logic [15:0] wdata, rdata, d;
	logic [3:0]  addr;
	logic        wr, slope;
	logic [12:0] dac;
	logic [1:0]  diag;
	int          fails = 0;
	int          total_checks = 0;
	int          cyc = 0;
	always #4 sys_clk_i = ~sys_clk_i;
	aocc_host aocc_host_i (.sys_clk_i, .rdata_i(rdata), .addr_o(addr),
		.wr_o(wr), .wdata_o(wdata));
	aocc_top aocc_top_i (.sys_clk_i, .srst_i, .reg_addr_i(addr),
		.reg_wr_i(wr), .reg_wdata_i(wdata), .zero_angle_i(zero),
		.angle_i, .reg_rdata_o(rdata), .dac_code_o(dac),
		.diag_level_o(diag), .slope_fall_o(slope));
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	task automatic rchk(input logic [3:0] a, input logic [15:0] e);
		aocc_host_i.rd(a, d);
		`CHK(d, e)
	endtask : rchk
	task automatic ang(input logic [15:0] a, input logic [12:0] e);
		@(negedge sys_clk_i);
		angle_i = a;
		repeat (4) @(negedge sys_clk_i);
		`CHK(dac, e)
	endtask : ang
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (12) @(negedge sys_clk_i);
		srst_i = 1'b0;
		rchk(4'h9, aocc_pkg::RST_GAIN_HI);
		rchk(4'ha, aocc_pkg::RST_GAIN_LO);
		rchk(4'hb, aocc_pkg::RST_LIM_LO);
		rchk(4'hc, aocc_pkg::RST_LIM_HI);
		rchk(4'h3, 16'h0000);
		aocc_host_i.wr(4'hb, 16'he200);
		rchk(4'hb, 16'h0200);
		aocc_host_i.wr(4'hc, 16'h1200);
		rchk(4'hc, 16'h1200);
		aocc_host_i.wr(4'h9, 16'h803f);
		rchk(4'h9, 16'h803f);
		aocc_host_i.wr(4'ha, 16'h1fff);
		rchk(4'ha, 16'h1fff);
		$display("test regs done");
		ang(16'h7f00, 13'h1200);
		ang(16'h0000, 13'h0200);
		ang(16'h8000, 13'h1200);
		ang(16'h8040, 13'h0200);
		aocc_host_i.wr(4'ha, 16'h7fff);
		ang(16'h0000, 13'h1200);
		`CHK(diag, 2'h1)
		`CHK(slope, 1'b1)
		@(negedge sys_clk_i);
		zero = 16'h8040;
		ang(16'h0000, 13'h0200);
		$display("test code done");
		tally_and_finish();
	end
endmodule : aocc_top_tb_top
`default_nettype wire

// >>> src/aocc_pkg.sv
// Constants, register map and field layout for the angle output clamp block.
// Assumes one core clock; registers are written by the one-wire front end.
// Overview of operation
// - Clamp words bits 12..0 are unsigned DAC codes, usable 256 to 4864.
// - Undefined clamp bits written zero by host; lower word bit 15 reads zero.
// - DAC scale is ratiometric; code 5120 equals full supply.
// - Gain upper part is bits 5..0 at 9h, weights 2^4 to 2^-1.
// - Gain lower part is bits 12..0 at Ah, weights 2^-2 to 2^-14.
// - Top bits at Ah hold diagnostic level and slope, not gain.
// - Switch point is bits 15..6 at 9h, fraction of 180 degrees.
// - Angle above switch point with rising slope outputs the lower clamp.
// - Zero angle is 16-bit unsigned fraction of 180 degrees.
package aocc_pkg;
	localparam logic [3:0]  ADDR_GAIN_HI   = 4'h9;
	localparam logic [3:0]  ADDR_GAIN_LO   = 4'ha;
	localparam logic [3:0]  ADDR_LIM_LO    = 4'hb;
	localparam logic [3:0]  ADDR_LIM_HI    = 4'hc;
	localparam logic [15:0] RST_GAIN_HI    = 16'hffc1;
	localparam logic [15:0] RST_GAIN_LO    = 16'h0400;
	localparam logic [15:0] RST_LIM_LO     = 16'h0100;
	localparam logic [15:0] RST_LIM_HI     = 16'h1300;
	localparam int          CODE_MSB       = 12;
	localparam int          GAIN_HI_MSB    = 5;
	localparam int          SW_LSB         = 6;
	localparam int          SLOPE_BIT      = 13;
	localparam int          DIAG_LSB       = 14;
	localparam logic [12:0] CODE_MIN       = 13'h0100;
	localparam logic [12:0] CODE_MAX       = 13'h1300;
	localparam logic [12:0] CODE_FULL      = 13'h1400;
	localparam logic [13:0] DAC_SPAN       = 14'h2000;
	localparam int          GAIN_FRAC      = 14;
	localparam logic [15:0] LIM_LO_RD_MASK = 16'h7fff;
endpackage : aocc_pkg

// >>> src/aocc_scale.sv
// Scales a zero-corrected angle by the span gain and limits to the clamps.
// Assumes stable configuration inputs; one cycle of latency.
`timescale 1ns/100ps
`default_nettype none
module aocc_scale (
	input  wire logic        sys_clk_i,
	input  wire logic        srst_i,
	input  wire logic [15:0] angle_i,
	input  wire logic [19:0] gain_i,
	input  wire logic [12:0] lim_lo_i,
	input  wire logic [12:0] lim_hi_i,
	output logic      [12:0] code_o
);
	logic [35:0] prod;
	logic [21:0] scaled;
	logic [22:0] sum;
	logic [12:0] code_nxt;
	always_comb begin
		// Angle fraction times 65536 times gain, gain has 14 fraction bits
		prod   = {20'h00000, angle_i} * {16'h0000, gain_i};
		scaled = prod[35:14];
		sum    = {1'b0, scaled} + {10'h000, lim_lo_i};
		if (sum > {10'h000, lim_hi_i})
			code_nxt = lim_hi_i;
		else
			code_nxt = sum[12:0];
	end
	always_ff @(posedge sys_clk_i) begin
		if (srst_i)
			code_o <= aocc_pkg::RST_LIM_LO[12:0];
		else
			code_o <= code_nxt;
	end
endmodule : aocc_scale
`default_nettype wire

// >>> src/aocc_top.sv
// Configuration words and angle-to-code transfer for one output channel.
// Assumes a word write/read port from the one-wire front end, same clock.
`timescale 1ns/100ps
`default_nettype none
module aocc_top (
	input  wire logic        sys_clk_i,
	input  wire logic        srst_i,
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic [15:0] reg_wdata_i,
	input  wire logic [15:0] zero_angle_i,
	input  wire logic [15:0] angle_i,
	output logic      [15:0] reg_rdata_o,
	output logic      [12:0] dac_code_o,
	output logic      [1:0]  diag_level_o,
	output logic             slope_fall_o
);
	logic [15:0] gain_hi_r;
	logic [15:0] gain_lo_r;
	logic [15:0] lim_lo_r;
	logic [15:0] lim_hi_r;
	logic [15:0] rdata_nxt;
	logic [19:0] gain;
	logic [9:0]  sw_point;
	logic [15:0] offs_angle;
	logic [15:0] offs_angle_r;
	logic [12:0] scaled_code;
	logic        past_sw_r;
	logic [12:0] dac_nxt;

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			gain_hi_r <= aocc_pkg::RST_GAIN_HI;
			gain_lo_r <= aocc_pkg::RST_GAIN_LO;
			lim_lo_r  <= aocc_pkg::RST_LIM_LO;
			lim_hi_r  <= aocc_pkg::RST_LIM_HI;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				aocc_pkg::ADDR_GAIN_HI: gain_hi_r <= reg_wdata_i;
				aocc_pkg::ADDR_GAIN_LO: gain_lo_r <= reg_wdata_i;
				aocc_pkg::ADDR_LIM_LO:  lim_lo_r  <= reg_wdata_i;
				aocc_pkg::ADDR_LIM_HI:  lim_hi_r  <= reg_wdata_i;
				default: ;
			endcase
		end
	end

	always_comb begin
		case (reg_addr_i)
			aocc_pkg::ADDR_GAIN_HI: rdata_nxt = gain_hi_r;
			aocc_pkg::ADDR_GAIN_LO: rdata_nxt = gain_lo_r;
			aocc_pkg::ADDR_LIM_LO:
				rdata_nxt = lim_lo_r & aocc_pkg::LIM_LO_RD_MASK;
			aocc_pkg::ADDR_LIM_HI:  rdata_nxt = lim_hi_r;
			default:                rdata_nxt = 16'h0000;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i)
			reg_rdata_o <= 16'h0000;
		else
			reg_rdata_o <= rdata_nxt;
	end

	// Gain: 6 upper bits then 13 lower bits, binary point 14 from bottom
	assign gain = {1'b0, gain_hi_r[aocc_pkg::GAIN_HI_MSB:0],
		gain_lo_r[aocc_pkg::CODE_MSB:0]};
	assign sw_point = gain_hi_r[15:aocc_pkg::SW_LSB];
	// Angle and zero share one scale, wrap modulo 180 degrees
	assign offs_angle = angle_i - zero_angle_i;

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			offs_angle_r <= 16'h0000;
			past_sw_r    <= 1'b0;
		end else begin
			offs_angle_r <= offs_angle;
			past_sw_r    <= offs_angle[15:6] > sw_point;
		end
	end

	aocc_scale u_scale (
		.sys_clk_i (sys_clk_i),
		.srst_i    (srst_i),
		.angle_i   (offs_angle_r),
		.gain_i    (gain),
		.lim_lo_i  (lim_lo_r[aocc_pkg::CODE_MSB:0]),
		.lim_hi_i  (lim_hi_r[aocc_pkg::CODE_MSB:0]),
		.code_o    (scaled_code)
	);

	logic past_sw_d_r;
	always_ff @(posedge sys_clk_i) begin
		if (srst_i)
			past_sw_d_r <= 1'b0;
		else
			past_sw_d_r <= past_sw_r;
	end

	always_comb begin
		if (past_sw_d_r)
			dac_nxt = lim_lo_r[aocc_pkg::CODE_MSB:0];
		else
			dac_nxt = scaled_code;
		// Falling slope mirrors code about the clamp window
		if (gain_lo_r[aocc_pkg::SLOPE_BIT])
			dac_nxt = lim_hi_r[12:0] - dac_nxt + lim_lo_r[12:0];
	end

	// Code units are 1/5120 of supply
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			dac_code_o   <= aocc_pkg::RST_LIM_LO[12:0];
			diag_level_o <= 2'h0;
			slope_fall_o <= 1'b0;
		end else begin
			dac_code_o   <= dac_nxt;
			diag_level_o <= gain_lo_r[15:aocc_pkg::DIAG_LSB];
			slope_fall_o <= gain_lo_r[aocc_pkg::SLOPE_BIT];
		end
	end
endmodule : aocc_top
`default_nettype wire
